/* shared/axis_done_defines.vh */
// Register offsets, field positions, command codes and reset values.
`ifndef AXIS_DONE_DEFINES_VH
`define AXIS_DONE_DEFINES_VH
// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define REG_CMD        12'h000
`define REG_PARAM      12'h004
`define REG_CFG        12'h008
`define REG_DONE_FLAGS 12'h00C
`define REG_STATUS     12'h010
`define REG_POSITION   12'h014
`define REG_AXIS_STATE 12'h018
`define REG_ALT_STATUS 12'h01C
// ------------------------------------------------------------------
// Command codes (low byte of the command register)
// ------------------------------------------------------------------
`define CMD_HOME_SEEK_FWD  8'h01
`define CMD_HOME_SEEK_REV  8'h02
`define CMD_HOME_HALT_FWD  8'h03
`define CMD_HOME_HALT_REV  8'h04
`define CMD_DONE_MARKER    8'h05
`define CMD_PER_AXIS_DONE  8'h06
`define CMD_NEARLY_DONE    8'h07
`define CMD_DEADBAND_DONE  8'h08
`define CMD_FLAG_CLEAR_ALL 8'h09
`define CMD_AXIS_CLEAR     8'h0A
`define CMD_MOVE_RESET     8'h0B
`define CMD_CTRL_CLEAR     8'h19
// ------------------------------------------------------------------
// Command register fields
// ------------------------------------------------------------------
`define CMD_AXIS_LSB   8
`define CMD_HAS_PARAM  10
`define CMD_SEL_LSB    12
// ------------------------------------------------------------------
// Configuration register fields
// ------------------------------------------------------------------
`define CFG_IRQ_EN     0
`define CFG_ALL_AXES   1
`define CFG_MOVED_AXES 2
`define CFG_HOLD_LSB   4
`define CFG_RESET      8'h00
// ------------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------------
`define STS_DONE       0
`define STS_ERROR      1
`define STS_HOMING     2
`define NUM_AXES       4
`endif

/* hw/axis_homing_done.v */
// Per-axis homing and move-completion flags for a step-pulse controller.
//
// Behaviour
// - Forward home seek steps positive at preset velocity until home is true.
// - At home during seek, load position from parameter, then decelerate.
// - Home seek without a parameter loads zero.
// - Reverse home seek steps negative, otherwise same as forward seek.
// - Forward home halt stops pulses at home at once, position untouched.
// - Reverse home halt steps negative, stops pulses at home at once, position untouched.
// - Done marker sets done flag and interrupts when enabled.
// - All-axes mode sets axis bits; summary done after all axes reach marker.
// - Moved-axes mode flags only axes given a move parameter in the last move.
// - Per-axis done raises a separate interrupt as each axis finishes.
// - Per-axis done interrupts only for axes given a move parameter.
// - Nearly-done compares remaining distance only while decelerating.
// - Threshold above ramp-down distance fires when deceleration begins.
// - Deadband done waits until the axis is inside its deadband.
// - Without position hold, deadband done sets done when the axis finishes, without waiting for deadband.
// - Clear command or control byte 0x19 clears done and error flags.
// - Flag clear executes at once, bypassing any command queue.
// - Reading axis or alternate status also clears done and error flags.
// - Single-axis clear resets only the addressed axis done flag and its per-axis pending flag.
`timescale 1ns/1ps
`include "axis_done_defines.vh"
module axis_homing_done (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [3:0]  home_in,
    input  wire [3:0]  axis_finished,
    input  wire [3:0]  axis_decel,
    input  wire [3:0]  axis_in_deadband,
    input  wire [3:0]  axis_error,
    input  wire [3:0]  move_start,
    input  wire [3:0]  move_has_param,
    input  wire [127:0] remaining_dist,
    output reg  [3:0]  step_enable,
    output reg  [3:0]  step_dir_neg,
    output reg  [3:0]  decel_request,
    output reg  [127:0] position,
    output reg         irq
);

// ------------------------------------------------------------------
// Bus decode
// ------------------------------------------------------------------
wire        wr_en   = psel & penable & pwrite;
wire        rd_en   = psel & penable & ~pwrite;
wire [7:0]  cmd     = pwdata[7:0];
wire [1:0]  cmd_ax  = pwdata[`CMD_AXIS_LSB+1:`CMD_AXIS_LSB];
wire        cmd_par = pwdata[`CMD_HAS_PARAM];
wire [3:0]  cmd_sel = pwdata[`CMD_SEL_LSB+3:`CMD_SEL_LSB];
wire        is_cmd  = wr_en & (paddr == `REG_CMD);

assign pready  = 1'b1;
assign pslverr = 1'b0;

function hit;
    input [7:0] code;
    begin
        hit = is_cmd & (cmd == code);
    end
endfunction

// ------------------------------------------------------------------
// State
// ------------------------------------------------------------------
reg [31:0] param;
reg [7:0]  cfg;
reg [3:0]  done_flags;
reg        sum_done;
reg        err_flag;
reg [3:0]  homing;
reg [3:0]  halt_mode;
reg [31:0] home_value [0:3];
reg [3:0]  moved;
reg [3:0]  marker_seen;
reg [3:0]  deadband_wait;
// The finish event may come before the axis settles, so it is remembered.
reg [3:0]  db_fin;
reg [3:0]  per_axis_arm;
reg [3:0]  per_axis_pend;
reg [3:0]  near_sel;
reg [3:0]  near_met;
reg        near_flag;
reg [127:0] near_thr;

wire irq_en  = cfg[`CFG_IRQ_EN];
wire all_ax  = cfg[`CFG_ALL_AXES];
wire mov_ax  = cfg[`CFG_MOVED_AXES];
wire [3:0] hold_en = cfg[`CFG_HOLD_LSB+3:`CFG_HOLD_LSB];

wire clr_all = hit(`CMD_FLAG_CLEAR_ALL) | hit(`CMD_CTRL_CLEAR) |
               (rd_en & ((paddr == `REG_AXIS_STATE) |
                         (paddr == `REG_ALT_STATUS)));

// ------------------------------------------------------------------
// Per-axis event terms
// ------------------------------------------------------------------
reg [3:0] marker_set;
reg [3:0] near_now;
reg [3:0] dl_ready;
integer k;
always @* begin
    marker_set = 4'h0;
    near_now   = 4'h0;
    dl_ready   = 4'h0;
    for (k = 0; k < `NUM_AXES; k = k + 1) begin
        // Deadband is only a gate when position hold is on.
        dl_ready[k] = axis_in_deadband[k] | ~hold_en[k];
        marker_set[k] = deadband_wait[k] & dl_ready[k] &
                        (axis_finished[k] | db_fin[k]);
        // A threshold beyond the ramp is met on the first decel cycle.
        near_now[k] = axis_decel[k] &
            (remaining_dist[k*32 +: 32] <= near_thr[k*32 +: 32]);
    end
end

// ------------------------------------------------------------------
// Homing
// ------------------------------------------------------------------
integer a;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        homing        <= 4'h0;
        halt_mode     <= 4'h0;
        step_enable   <= 4'h0;
        step_dir_neg  <= 4'h0;
        decel_request <= 4'h0;
        position      <= 128'h0;
        for (a = 0; a < `NUM_AXES; a = a + 1) begin
            home_value[a] <= 32'h0;
        end
    end else begin
        decel_request <= 4'h0;
        for (a = 0; a < `NUM_AXES; a = a + 1) begin
            if (homing[a] && home_in[a]) begin
                homing[a] <= 1'b0;
                if (halt_mode[a]) begin
                    step_enable[a] <= 1'b0;
                end else begin
                    position[a*32 +: 32] <= home_value[a];
                    decel_request[a]     <= 1'b1;
                end
            end
            if (axis_finished[a] && !homing[a]) begin
                step_enable[a] <= 1'b0;
            end
        end
        if (hit(`CMD_HOME_SEEK_FWD) || hit(`CMD_HOME_SEEK_REV) ||
            hit(`CMD_HOME_HALT_FWD) || hit(`CMD_HOME_HALT_REV)) begin
            homing[cmd_ax]      <= 1'b1;
            step_enable[cmd_ax] <= 1'b1;
            step_dir_neg[cmd_ax] <= hit(`CMD_HOME_SEEK_REV) |
                                    hit(`CMD_HOME_HALT_REV);
            halt_mode[cmd_ax]   <= hit(`CMD_HOME_HALT_FWD) |
                                   hit(`CMD_HOME_HALT_REV);
            home_value[cmd_ax]  <= cmd_par ? param : 32'h0;
        end
    end
end

// ------------------------------------------------------------------
// Done flags and interrupt sources
// ------------------------------------------------------------------
integer b;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        param         <= 32'h0;
        cfg           <= `CFG_RESET;
        done_flags    <= 4'h0;
        sum_done      <= 1'b0;
        err_flag      <= 1'b0;
        moved         <= 4'h0;
        marker_seen   <= 4'h0;
        deadband_wait <= 4'h0;
        db_fin        <= 4'h0;
        per_axis_arm  <= 4'h0;
        per_axis_pend <= 4'h0;
        near_sel      <= 4'h0;
        near_met      <= 4'h0;
        near_flag     <= 1'b0;
        near_thr      <= 128'h0;
    end else begin
        if (wr_en && paddr == `REG_PARAM) begin
            param <= pwdata;
        end
        if (wr_en && paddr == `REG_CFG) begin
            cfg <= pwdata[7:0];
        end
        if (|move_start) begin
            moved <= move_has_param;
        end
        // Clears come first so that any set in this cycle wins.
        if (clr_all) begin
            done_flags    <= 4'h0;
            sum_done      <= 1'b0;
            err_flag      <= 1'b0;
            per_axis_pend <= 4'h0;
            near_flag     <= 1'b0;
            marker_seen   <= 4'h0;
        end
        if (hit(`CMD_AXIS_CLEAR)) begin
            done_flags[cmd_ax]    <= 1'b0;
            per_axis_pend[cmd_ax] <= 1'b0;
        end
        if (hit(`CMD_MOVE_RESET)) begin
            done_flags <= 4'h0;
            sum_done   <= 1'b0;
        end
        if (|axis_error) begin
            err_flag <= 1'b1;
        end
        if (hit(`CMD_DONE_MARKER)) begin
            if (all_ax) begin
                done_flags  <= done_flags | cmd_sel;
                marker_seen <= marker_seen | cmd_sel;
                if ((marker_seen | cmd_sel) == 4'hF) begin
                    sum_done    <= 1'b1;
                    marker_seen <= 4'h0;
                end
            end else if (mov_ax) begin
                done_flags <= done_flags | moved;
                sum_done   <= sum_done | (|moved);
            end else begin
                done_flags[cmd_ax] <= 1'b1;
                sum_done           <= 1'b1;
            end
        end
        if (hit(`CMD_DEADBAND_DONE)) begin
            deadband_wait[cmd_ax] <= 1'b1;
            db_fin[cmd_ax]        <= 1'b0;
        end
        for (b = 0; b < `NUM_AXES; b = b + 1) begin
            if (deadband_wait[b] && axis_finished[b]) begin
                db_fin[b] <= 1'b1;
            end
            if (marker_set[b]) begin
                deadband_wait[b] <= 1'b0;
                db_fin[b]        <= 1'b0;
                done_flags[b]    <= 1'b1;
                sum_done         <= 1'b1;
            end
            if (per_axis_arm[b] && axis_finished[b]) begin
                per_axis_arm[b]  <= 1'b0;
                per_axis_pend[b] <= 1'b1;
                done_flags[b]    <= 1'b1;
            end
        end
        if (hit(`CMD_PER_AXIS_DONE)) begin
            per_axis_arm <= moved;
        end
        if (hit(`CMD_NEARLY_DONE)) begin
            near_sel <= cmd_sel;
            near_met <= 4'h0;
            near_thr[cmd_ax*32 +: 32] <= param;
        end else if (near_sel != 4'h0) begin
            if (((near_met | near_now) & near_sel) == near_sel) begin
                near_flag <= 1'b1;
                near_sel  <= 4'h0;
            end else begin
                near_met <= near_met | near_now;
            end
        end
    end
end

// ------------------------------------------------------------------
// Interrupt and read data
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq <= 1'b0;
    end else begin
        irq <= irq_en & (sum_done | err_flag | near_flag |
                         (|per_axis_pend));
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
        case (paddr)
            `REG_PARAM:      prdata <= param;
            `REG_CFG:        prdata <= {24'h0, cfg};
            `REG_DONE_FLAGS: prdata <= {28'h0, done_flags};
            `REG_STATUS:     prdata <= {29'h0, |homing, err_flag, sum_done};
            `REG_POSITION:   prdata <= position[31:0];
            `REG_AXIS_STATE: prdata <= {20'h0, per_axis_pend, homing,
                                        done_flags};
            `REG_ALT_STATUS: prdata <= {28'h0, near_flag, |homing,
                                        err_flag, sum_done};
            default:         prdata <= 32'h0;
        endcase
    end
end

endmodule

/* sim/axis_homing_chk.sv */
// Concurrent checks on the homing and completion block ports.
`timescale 1ns/1ps
module axis_homing_chk (
    input logic         pclk,
    input logic         presetn,
    input logic         psel,
    input logic         penable,
    input logic         pwrite,
    input logic [11:0]  paddr,
    input logic [31:0]  pwdata,
    input logic [3:0]   home_in,
    input logic [3:0]   step_enable,
    input logic [3:0]   step_dir_neg,
    input logic [127:0] position,
    input logic         irq
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && paddr[11:5] == 7'h00;
    wire cmd = acc && pwrite && paddr == 12'h000;
    sequence cmd_wr(c);
        cmd && pwdata[7:0] == c;
    endsequence
    // Flags are registered, then irq one cycle later.
    sequence irq_gone;
        ##[1:3] !irq;
    endsequence
    halt_stop_a: assert property ($fell(step_enable[0]) |-> $past(home_in[0]))
        else $error("pulses stopped away from home");
    pos_load_a: assert property ($changed(position) |-> $past(|home_in))
        else $error("position changed without home");
    dir_hold_a: assert property (step_enable[0] && $past(step_enable[0])
        |-> $stable(step_dir_neg[0]))
        else $error("direction changed in motion");
    seek_start_a: assert property ($rose(step_enable[0])
        |-> $past(cmd) || $past(cmd, 2))
        else $error("pulses started without command");
    clear_cmd_a: assert property (cmd_wr(8'h09) |-> irq_gone)
        else $error("clear left irq high");
    ctrl_clear_a: assert property (cmd_wr(8'h19) |-> irq_gone)
        else $error("control clear left irq high");
    read_clear_a: assert property (acc && !pwrite && paddr[4:3] == 2'b11
        |-> irq_gone)
        else $error("status read left irq high");
    irq_hold_a: assert property ($fell(irq)
        |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
        else $error("irq dropped with flags set");
endmodule
bind axis_homing_done axis_homing_chk axis_homing_chk_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .home_in(home_in), .irq(irq),
    .step_enable(step_enable), .step_dir_neg(step_dir_neg),
    .position(position));

/* sim/axis_motion_model.sv */
// Behavioural axis stage: home switch and deceleration ramp per axis.
`timescale 1ns/1ps
module axis_motion_model #(
    parameter int HOME_STEPS = 6,
    parameter int DECEL_CYC  = 4
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] step_enable,
    input  wire logic [3:0] decel_request,
    output logic [3:0]      home_in,
    output logic [3:0]      axis_decel,
    output logic [3:0]      axis_finished
);
    logic [3:0] sc [4];
    logic [3:0] dc [4];
    always @(posedge pclk or negedge presetn) begin
        for (int k = 0; k < 4; k++) begin
            if (!presetn) begin
                sc[k] <= 4'h0;
                dc[k] <= 4'h0;
                home_in[k] <= 1'b0;
                axis_decel[k] <= 1'b0;
                axis_finished[k] <= 1'b0;
            end else begin
                // Slow approach: switch closes only after several steps.
                if (!step_enable[k]) sc[k] <= 4'h0;
                else if (sc[k] < HOME_STEPS) sc[k] <= sc[k] + 4'h1;
                home_in[k] <= step_enable[k] && sc[k] >= HOME_STEPS - 1;
                if (decel_request[k]) dc[k] <= 4'(DECEL_CYC);
                else if (dc[k] != 4'h0) dc[k] <= dc[k] - 4'h1;
                axis_decel[k] <= decel_request[k] || dc[k] > 4'h1;
                axis_finished[k] <= dc[k] == 4'h1;
            end
        end
    end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the homing and completion block.
`timescale 1ns/1ps
module tb_top;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]  paddr = 0, a;
    logic [31:0]  pwdata = 0, p_val;
    logic [3:0]   axis_error = 0, move_start = 0, move_has_param = 0;
    logic [3:0]   tb_decel = 0, tb_fin = 0, tb_db = 0;
    logic [127:0] remaining_dist = 0;
    logic [63:0]  e, expq[$];
    logic [11:0]  addrq[$];
    wire  [31:0]  prdata;
    wire          pready, pslverr, irq;
    wire  [3:0]   home_in, m_decel, m_fin, step_enable, step_dir_neg, dreq;
    wire  [127:0] position;
    int           mismatches = 0, n_compared = 0, cyc = 0;
    always #12.5 pclk = ~pclk;
    axis_homing_done axis_homing_done_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .home_in(home_in), .axis_finished(m_fin | tb_fin),
        .axis_decel(m_decel | tb_decel), .axis_in_deadband(tb_db),
        .axis_error(axis_error), .move_start(move_start),
        .move_has_param(move_has_param), .remaining_dist(remaining_dist),
        .step_enable(step_enable), .step_dir_neg(step_dir_neg),
        .decel_request(dreq), .position(position), .irq(irq));
    axis_motion_model axis_motion_model_inst (.pclk(pclk), .presetn(presetn),
        .step_enable(step_enable), .decel_request(dreq), .home_in(home_in),
        .axis_decel(m_decel), .axis_finished(m_fin));
    task automatic chk(input string n, input logic [127:0] x, s);
        n_compared++;
        if (s !== x) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic xfer(input logic [11:0] ad, input logic w,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        xfer(ad, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] x, m);
        expq.push_back({m, x});
        addrq.push_back(ad);
        xfer(ad, 1'b0, 32'h0);
    endtask
    task automatic wait_for(input int sel, input int k);
        for (int i = 0; i < 60; i++) begin
            @(posedge pclk);
            if (sel == 0 && dreq[k] === 1'b1) break;
            if (sel == 1 && step_enable[k] === 1'b0) break;
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // ------------------------------------------------------------
    // Read monitor and hang guard
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
        if (psel && penable && !pwrite && pready) begin
            e = expq.pop_front();
            a = addrq.pop_front();
            chk($sformatf("reg %h", a), e[31:0] & e[63:32], prdata & e[63:32]);
        end
    end
    initial begin
        p_val = $urandom(32'h0EE86C63);
        p_val = ($urandom & 32'h0000FFFF) | 32'h00000001;
        cyc_n(16);
        presetn <= 1;
        cyc_n(1);
        chk("irq", 0, irq);
        wr(12'h004, p_val);
        wr(12'h000, 32'h00000401);
        cyc_n(3);
        chk("run0", 4'h1, {step_dir_neg[0], 2'b0, step_enable[0]});
        wait_for(0, 0);
        cyc_n(2);
        chk("pos0", p_val, position[31:0]);
        rd(12'h014, p_val, 32'hFFFFFFFF);
        wait_for(1, 0);
        wr(12'h000, 32'h00000003);
        cyc_n(3);
        wait_for(1, 0);
        chk("pos0", p_val, position[31:0]);
        wr(12'h000, 32'h00000004);
        cyc_n(3);
        chk("dir0", 1, step_dir_neg[0]);
        wait_for(1, 0);
        chk("pos0", p_val, position[31:0]);
        wr(12'h000, 32'h00000002);
        cyc_n(3);
        chk("dir0", 1, step_dir_neg[0]);
        wait_for(0, 0);
        cyc_n(2);
        chk("pos0", 0, position[31:0]);
        wait_for(1, 0);
        $display("homing test done");
        wr(12'h008, 32'h00000001);
        wr(12'h000, 32'h00000005);
        cyc_n(3);
        chk("irq", 1, irq);
        rd(12'h010, 32'h1, 32'h1);
        wr(12'h000, 32'h00000009);
        cyc_n(3);
        chk("irq", 0, irq);
        rd(12'h010, 32'h0, 32'h3);
        wr(12'h000, 32'h00000005);
        wr(12'h000, 32'h00000019);
        cyc_n(3);
        chk("irq", 0, irq);
        $display("clear test done");
        wr(12'h008, 32'h00000003);
        wr(12'h000, 32'h00003005);
        rd(12'h00C, 32'h3, 32'hF);
        rd(12'h010, 32'h0, 32'h1);
        wr(12'h000, 32'h0000C005);
        rd(12'h010, 32'h1, 32'h1);
        wr(12'h000, 32'h0000010A);
        rd(12'h00C, 32'hD, 32'hF);
        rd(12'h018, 32'h0, 32'h0);
        rd(12'h00C, 32'h0, 32'hF);
        wr(12'h008, 32'h00000005);
        move_start <= 4'h5;
        move_has_param <= 4'h5;
        cyc_n(1);
        move_start <= 4'h0;
        wr(12'h000, 32'h0000F005);
        rd(12'h00C, 32'h5, 32'hF);
        axis_error <= 4'h4;
        cyc_n(1);
        axis_error <= 4'h0;
        cyc_n(3);
        chk("irq", 1, irq);
        rd(12'h01C, 32'h0, 32'h0);
        rd(12'h010, 32'h0, 32'h3);
        $display("flag test done");
        // The threshold must be armed before the move starts.
        wr(12'h004, 32'h00000064);
        wr(12'h000, 32'h00001007);
        move_start <= 4'h3;
        move_has_param <= 4'h1;
        remaining_dist[31:0] <= 32'h00000032;
        cyc_n(1);
        move_start <= 4'h0;
        cyc_n(6);
        chk("irq", 0, irq);
        tb_decel <= 4'h1;
        cyc_n(4);
        chk("irq", 1, irq);
        tb_decel <= 4'h0;
        wr(12'h000, 32'h00000009);
        wr(12'h000, 32'h00000006);
        tb_fin <= 4'h2;
        cyc_n(1);
        tb_fin <= 4'h0;
        cyc_n(3);
        chk("irq", 0, irq);
        tb_fin <= 4'h1;
        cyc_n(1);
        tb_fin <= 4'h0;
        cyc_n(3);
        chk("irq", 1, irq);
        chk("pslverr", 0, pslverr);
        $display("interrupt test done");
        wr(12'h000, 32'h00000009);
        wr(12'h008, 32'h00000011);
        wr(12'h000, 32'h00000008);
        tb_fin <= 4'h1;
        cyc_n(1);
        tb_fin <= 4'h0;
        cyc_n(3);
        rd(12'h00C, 32'h0, 32'hF);
        tb_db <= 4'h1;
        cyc_n(3);
        rd(12'h00C, 32'h1, 32'hF);
        chk("irq", 1, irq);
        wr(12'h000, 32'h0000000B);
        rd(12'h00C, 32'h0, 32'hF);
        tb_db <= 4'h0;
        wr(12'h008, 32'h00000001);
        wr(12'h000, 32'h00000008);
        tb_fin <= 4'h1;
        cyc_n(1);
        tb_fin <= 4'h0;
        cyc_n(3);
        rd(12'h00C, 32'h1, 32'hF);
        $display("deadband test done");
        tally_and_finish();
    end
endmodule
